// ===== src/dual_timer_defs.vh
// Purpose: constants for the dual timer/counter pair
// Assumes: registers reached over a plain address/strobe port
// Notes: offsets are word indices on the local register port
//
// What this block does
// - low byte overflow bumps high byte; high byte overflow sets the unit's flag
// - setting run bit continues from held count bytes, nothing cleared
// - timer source counts once per six-clock peripheral cycle
// - counter source samples pin per cycle, counts on high-then-low samples
// - unit zero uses mode low nibble and control bits 4,5
// - gate clear: run bit alone enables; gate set adds gate pin
// - rollover from all ones to zero sets overflow flag and interrupt request
// - mode 0 is thirteen bits: five-bit prescaler then high byte
// - mode 2 counts low byte, reloads from high byte on overflow
// - overflow flag cleared by hardware when interrupt is serviced
// - unit zero mode 3 low byte is own 8-bit counter
// - unit zero mode 3 high byte times by six, uses unit one run and flag
// - unit one modes 0..2 as unit zero; mode 3 holds count
// - unit one uses mode high nibble and control bits 6,7
// - unit one overflow offered as serial baud source, except while unit zero is in mode 3 (then unit zero high byte overflow)
// - gate set: counts only while gate pin high and run set
// - mode field 01 sixteen bit, 10 auto-reload, 11 mode 3
// - control, mode and count bytes reset to zero
`ifndef DUAL_TIMER_DEFS_VH
`define DUAL_TIMER_DEFS_VH
`define ADDR_CTRL        3'h0
`define ADDR_MODE        3'h1
`define ADDR_LOW0        3'h2
`define ADDR_LOW1        3'h3
`define ADDR_HIGH0       3'h4
`define ADDR_HIGH1       3'h5
`define RESET_BYTE       8'h00
`define PER_CYCLE_CLKS   3'h6
`define MODE_13BIT       2'h0
`define MODE_16BIT       2'h1
`define MODE_RELOAD      2'h2
`define MODE_SPLIT       2'h3
`define CTRL_RUN0        4
`define CTRL_FLAG0       5
`define CTRL_RUN1        6
`define CTRL_FLAG1       7
`endif

// ===== src/dual_timer_counter_pair.v
// Purpose: two 16-bit timer/counters with 13-bit, 16-bit, reload and split modes
// Assumes: clk is the peripheral clock; pins are asynchronous to it
// Notes: control bits 0..3 (external interrupt) are plain storage here
// Notes: control bits sit in four flop groups (bits 0..4 with run0, run1, flag0, flag1) so that every bit has one driver
// Notes: overflow flags favour the hardware set over a same-cycle clear
//
// Added by the designer: the register offsets and the plain strobed port.
`include "dual_timer_defs.vh"
`default_nettype none
module dual_timer_counter_pair
(
   input  wire       clk,
   input  wire       sys_rst,
   input  wire [2:0] addr,
   input  wire [7:0] wr_data,
   input  wire       wr_stb,
   input  wire       rd_stb,
   output reg  [7:0] rd_data,
   input  wire       count_pin_unit0,
   input  wire       count_pin_unit1,
   input  wire       gate_pin_unit0,
   input  wire       gate_pin_unit1,
   input  wire       irq_ack_unit0,
   input  wire       irq_ack_unit1,
   output wire       irq_unit0,
   output wire       irq_unit1,
   output reg        baud_tick
);
   wire [7:0] ctrl_q;
   reg  [4:0] ctrl_lo_q;
   reg        run1_q;
   reg        flag0_q;
   reg        flag1_q;
   reg  [7:0] mode_q;
   reg  [7:0] low0_q;
   reg  [7:0] low1_q;
   reg  [7:0] high0_q;
   reg  [7:0] high1_q;
   reg  [2:0] div_q;
   reg  [1:0] cp0_s;
   reg  [1:0] cp1_s;
   reg  [1:0] gp0_s;
   reg  [1:0] gp1_s;
   reg        cp0_last_q;
   reg        cp1_last_q;
   wire       per_tick;
   wire       src0;
   wire       src1;
   wire       en0;
   wire       en1;
   wire [1:0] m0;
   wire [1:0] m1;
   reg  [7:0] low0_d;
   reg  [7:0] high0_d;
   reg  [7:0] low1_d;
   reg  [7:0] high1_d;
   reg        ovf0;
   reg        ovf1;

   // peripheral cycle strobe: one clk in six
   assign per_tick = (div_q == `PER_CYCLE_CLKS - 3'h1);
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         div_q <= 3'h0;
      else if (per_tick)
         div_q <= 3'h0;
      else
         div_q <= div_q + 3'h1;
   end

   // two-flop synchronisers; only the second stage is read
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cp0_s <= 2'h0;
         cp1_s <= 2'h0;
         gp0_s <= 2'h0;
         gp1_s <= 2'h0;
      end
      else
      begin
         cp0_s <= {cp0_s[0], count_pin_unit0};
         cp1_s <= {cp1_s[0], count_pin_unit1};
         gp0_s <= {gp0_s[0], gate_pin_unit0};
         gp1_s <= {gp1_s[0], gate_pin_unit1};
      end
   end

   // count pins sampled once per peripheral cycle
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         cp0_last_q <= 1'b0;
         cp1_last_q <= 1'b0;
      end
      else if (per_tick)
      begin
         cp0_last_q <= cp0_s[1];
         cp1_last_q <= cp1_s[1];
      end
   end

   assign m0 = mode_q[1:0];
   assign m1 = mode_q[5:4];

   // selected input: timer tick or sampled falling edge
   assign src0 = mode_q[2] ? (per_tick & cp0_last_q & ~cp0_s[1])
                           : per_tick;
   assign src1 = mode_q[6] ? (per_tick & cp1_last_q & ~cp1_s[1])
                           : per_tick;
   // gate only restricts, never replaces, the run bit
   assign en0 = ctrl_q[`CTRL_RUN0] & (~mode_q[3] | gp0_s[1]);
   assign en1 = ctrl_q[`CTRL_RUN1] & (~mode_q[7] | gp1_s[1]);

   // next count values; counting continues from held bytes
   always @*
   begin
      low0_d  = low0_q;
      high0_d = high0_q;
      low1_d  = low1_q;
      high1_d = high1_q;
      ovf0    = 1'b0;
      ovf1    = 1'b0;
      if (en0 & src0)
      begin
         case (m0)
            `MODE_13BIT:
            begin
               low0_d = {low0_q[7:5], low0_q[4:0] + 5'h01};
               if (low0_q[4:0] == 5'h1f)
               begin
                  high0_d = high0_q + 8'h01;
                  ovf0    = (high0_q == 8'hff);
               end
            end
            `MODE_16BIT:
            begin
               low0_d = low0_q + 8'h01;
               if (low0_q == 8'hff)
               begin
                  high0_d = high0_q + 8'h01;
                  ovf0    = (high0_q == 8'hff);
               end
            end
            `MODE_RELOAD:
            begin
               low0_d = (low0_q == 8'hff) ? high0_q : low0_q + 8'h01;
               ovf0   = (low0_q == 8'hff);
            end
            default:
            begin
               low0_d = low0_q + 8'h01;
               ovf0   = (low0_q == 8'hff);
            end
         endcase
      end
      // split mode: high byte of unit zero on unit one's run bit
      if (m0 == `MODE_SPLIT && ctrl_q[`CTRL_RUN1] && per_tick)
      begin
         high0_d = high0_q + 8'h01;
         ovf1    = (high0_q == 8'hff);
      end
      if (en1 & src1)
      begin
         case (m1)
            `MODE_13BIT:
            begin
               low1_d = {low1_q[7:5], low1_q[4:0] + 5'h01};
               if (low1_q[4:0] == 5'h1f)
               begin
                  high1_d = high1_q + 8'h01;
                  ovf1    = ovf1 | (m0 != `MODE_SPLIT && high1_q == 8'hff);
               end
            end
            `MODE_16BIT:
            begin
               low1_d = low1_q + 8'h01;
               if (low1_q == 8'hff)
               begin
                  high1_d = high1_q + 8'h01;
                  ovf1    = ovf1 | (m0 != `MODE_SPLIT && high1_q == 8'hff);
               end
            end
            `MODE_RELOAD:
            begin
               low1_d = (low1_q == 8'hff) ? high1_q : low1_q + 8'h01;
               ovf1   = ovf1 | (m0 != `MODE_SPLIT && low1_q == 8'hff);
            end
            default:
            begin
               low1_d = low1_q;
            end
         endcase
      end
   end

   // count bytes; hardware updates yield to a software write of the same byte
   // a write while running is the user's problem, the write simply wins
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         low0_q  <= `RESET_BYTE;
         low1_q  <= `RESET_BYTE;
         high0_q <= `RESET_BYTE;
         high1_q <= `RESET_BYTE;
      end
      else
      begin
         low0_q  <= (wr_stb && addr == `ADDR_LOW0)  ? wr_data : low0_d;
         low1_q  <= (wr_stb && addr == `ADDR_LOW1)  ? wr_data : low1_d;
         high0_q <= (wr_stb && addr == `ADDR_HIGH0) ? wr_data : high0_d;
         high1_q <= (wr_stb && addr == `ADDR_HIGH1) ? wr_data : high1_d;
      end
   end

   // mode register: no guard against a change while running
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         mode_q <= `RESET_BYTE;
      else if (wr_stb && addr == `ADDR_MODE)
         mode_q <= wr_data;
   end

   // run bits and external-interrupt storage bits, software only
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ctrl_lo_q <= 5'h00;
         run1_q    <= 1'b0;
      end
      else if (wr_stb && addr == `ADDR_CTRL)
      begin
         ctrl_lo_q <= wr_data[`CTRL_RUN0:0];
         run1_q    <= wr_data[`CTRL_RUN1];
      end
   end

   // flag of unit zero: a same-cycle overflow beats both write and service clear
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         flag0_q <= 1'b0;
      else if (ovf0)
         flag0_q <= 1'b1;
      else if (wr_stb && addr == `ADDR_CTRL)
         flag0_q <= wr_data[`CTRL_FLAG0];
      else if (irq_ack_unit0)
         flag0_q <= 1'b0;
   end

   // flag of unit one; in split mode it belongs to the high byte of unit zero
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         flag1_q <= 1'b0;
      else if (ovf1)
         flag1_q <= 1'b1;
      else if (wr_stb && addr == `ADDR_CTRL)
         flag1_q <= wr_data[`CTRL_FLAG1];
      else if (irq_ack_unit1)
         flag1_q <= 1'b0;
   end

   // control byte as software sees it
   assign ctrl_q = {flag1_q, run1_q, flag0_q, ctrl_lo_q};

   assign irq_unit0 = ctrl_q[`CTRL_FLAG0];
   assign irq_unit1 = ctrl_q[`CTRL_FLAG1];

   // baud source: one-cycle pulse on every ovf1 event (unit one, or unit zero high byte in split mode)
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         baud_tick <= 1'b0;
      else
         baud_tick <= ovf1;
   end

   // read port: data stand the cycle after the strobe; unmapped reads zero
   always @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         rd_data <= 8'h00;
      else if (rd_stb)
      begin
         case (addr)
            `ADDR_CTRL:  rd_data <= ctrl_q;
            `ADDR_MODE:  rd_data <= mode_q;
            `ADDR_LOW0:  rd_data <= low0_q;
            `ADDR_LOW1:  rd_data <= low1_q;
            `ADDR_HIGH0: rd_data <= high0_q;
            `ADDR_HIGH1: rd_data <= high1_q;
            default:     rd_data <= 8'h00;
         endcase
      end
      else
         rd_data <= 8'h00;
   end
endmodule
`default_nettype wire

// ===== test/dual_timer_counter_pair_properties.sv
// Purpose: port checks for the timer pair
// Assumes: bound to the top module
// Notes: flags are seen on irq_unit0/1
`default_nettype none
module dual_timer_counter_pair_properties
(
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic [2:0] addr,
   input wire logic       wr_stb,
   input wire logic       rd_stb,
   input wire logic [7:0] rd_data,
   input wire logic       irq_ack_unit0,
   input wire logic       irq_ack_unit1,
   input wire logic       irq_unit0,
   input wire logic       irq_unit1,
   input wire logic       baud_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // read data only in the cycle after a strobe
   a_rd_idle_zero: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
      else $error("read data not idle");
   a_rd_unmapped: assert property ($past(rd_stb) && $past(addr) > 3'h5 |-> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_flag_bits: assert property ($past(rd_stb) && $past(addr) == 3'h0 |->
      rd_data[5] == $past(irq_unit0) && rd_data[7] == $past(irq_unit1))
      else $error("flag bits misplaced");
   // baud ticks come at most once per six clocks
   a_tick_gap: assert property (baud_tick |=> !baud_tick [*5])
      else $error("baud ticks too close");
   a_flag1_tick: assert property ($rose(irq_unit1) && !$past(wr_stb) |-> ##[0:1] baud_tick)
      else $error("flag1 rose without tick");
   a_flag0_holds: assert property (irq_unit0 && !irq_ack_unit0 && !(wr_stb && addr == 3'h0) |=> irq_unit0)
      else $error("flag0 dropped");
   a_flag1_holds: assert property (irq_unit1 && !irq_ack_unit1 && !(wr_stb && addr == 3'h0) |=> irq_unit1)
      else $error("flag1 dropped");
   a_ack1_clears: assert property (irq_ack_unit1 && !wr_stb ##1 irq_unit1 |-> ##[0:1] baud_tick)
      else $error("ack left flag1 set");
endmodule
bind dual_timer_counter_pair dual_timer_counter_pair_properties chk_u (.clk, .sys_rst, .addr, .wr_stb,
   .rd_stb, .rd_data, .irq_ack_unit0, .irq_ack_unit1, .irq_unit0, .irq_unit1, .baud_tick);
`default_nettype wire

// ===== test/pin_source.sv
// Purpose: far-side source of count pin edges
// Assumes: pin idles high
// Notes: each level lasts 12 clocks
`default_nettype none
module pin_source
(
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic [7:0] n,
   output var  logic       pin,
   output var  logic       busy
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] t_q = 4'h0;
   logic [8:0] k_q = 9'h000;
   initial pin = 1'b1;
   initial busy = 1'b0;
   // n falling edges; two sampling cycles per level
   always @(posedge clk)
   begin
      if (go)
      begin
         k_q <= {n, 1'b0};
         busy <= 1'b1;
         t_q <= 4'h0;
      end
      else if (busy && t_q == 4'hb)
      begin
         t_q <= 4'h0;
         pin <= ~pin;
         k_q <= k_q - 9'h001;
         busy <= k_q != 9'h001;
      end
      else if (busy)
         t_q <= t_q + 4'h1;
   end
endmodule
`default_nettype wire

// ===== test/dual_timer_counter_pair_tb.sv
// Purpose: self-checking bench for the timer pair
// Assumes: 25 MHz clock
// Notes: bus tasks change inputs after the edge
`default_nettype none
module dual_timer_counter_pair_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 0, sys_rst = 1, wr_stb = 0, rd_stb = 0;
   logic       go = 0, g0 = 1, g1 = 1, a0 = 0, a1 = 0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wr_data = 8'h00, n = 8'h00, nb = 8'h00;
   logic [7:0] rd_data;
   wire        pin, busy, irq_unit0, irq_unit1, baud_tick;
   int         num_errors = 0, n_compared = 0;
   dual_timer_counter_pair dut_u (.clk, .sys_rst, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data,
      .count_pin_unit0(pin), .count_pin_unit1(pin), .gate_pin_unit0(g0), .gate_pin_unit1(g1),
      .irq_ack_unit0(a0), .irq_ack_unit1(a1), .irq_unit0, .irq_unit1, .baud_tick);
   pin_source src_u (.clk, .go, .n, .pin, .busy);
   always #20 clk = ~clk;
   // count baud pulses seen
   always @(posedge clk)
      if (baud_tick === 1'b1) nb <= nb + 8'h01;
   task chk8(input logic [7:0] g, input logic [7:0] e);
      n_compared++;
      if (g !== e)
      begin
         num_errors++;
         $display("mismatch at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask
   task rd(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      @(negedge clk);
      chk8(rd_data, e);
   endtask
   task wflag(input logic u, input int lim);
      for (int i = 0; i < lim && (u ? irq_unit1 : irq_unit0) !== 1'b1; i++) @(negedge clk);
      chk8({7'h00, u ? irq_unit1 : irq_unit0}, 8'h01);
   endtask
   task ack(input logic u);
      @(posedge clk);
      if (u) a1 <= 1'b1; else a0 <= 1'b1;
      @(posedge clk);
      a0 <= 1'b0;
      a1 <= 1'b0;
      @(negedge clk);
      chk8({7'h00, u ? irq_unit1 : irq_unit0}, 8'h00);
   endtask
   task pulses(input logic [7:0] k);
      @(posedge clk);
      n <= k;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 600 && busy; i++) @(posedge clk);
      repeat (24) @(posedge clk);
   endtask
   task t_reset;
      for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
      wr(3'h7, 8'hff);
      rd(3'h7, 8'h00);
   endtask
   task t_timer16;
      wr(3'h1, 8'h01);
      wr(3'h2, 8'hfd);
      wr(3'h4, 8'hff);
      wr(3'h0, 8'h10);
      repeat (11) @(negedge clk);
      chk8({7'h00, irq_unit0}, 8'h00);
      wflag(1'b0, 10);
      wr(3'h0, 8'h20);
      rd(3'h2, 8'h00);
      rd(3'h4, 8'h00);
      ack(1'b0);
   endtask
   task t_mode13;
      wr(3'h1, 8'h00);
      wr(3'h4, 8'hff);
      wr(3'h2, 8'h1f);
      wr(3'h0, 8'h10);
      wflag(1'b0, 10);
      wr(3'h0, 8'h00);
      rd(3'h4, 8'h00);
   endtask
   task t_reload;
      nb <= 8'h00;
      wr(3'h1, 8'h20);
      wr(3'h5, 8'hfe);
      wr(3'h3, 8'hff);
      wr(3'h0, 8'h40);
      wflag(1'b1, 10);
      wr(3'h0, 8'h80);
      rd(3'h3, 8'hfe);
      rd(3'h5, 8'hfe);
      chk8(nb, 8'h01);
      ack(1'b1);
   endtask
   task t_count;
      wr(3'h1, 8'h05);
      wr(3'h2, 8'h00);
      wr(3'h4, 8'h00);
      wr(3'h0, 8'h10);
      pulses(8'h03);
      rd(3'h2, 8'h03);
      wr(3'h0, 8'h00);
      wr(3'h1, 8'h0d);
      wr(3'h0, 8'h10);
      @(posedge clk) g0 <= 1'b0;
      pulses(8'h02);
      rd(3'h2, 8'h03);
      @(posedge clk) g0 <= 1'b1;
      pulses(8'h01);
      rd(3'h2, 8'h04);
      wr(3'h0, 8'h00);
   endtask
   task t_split;
      nb <= 8'h00;
      wr(3'h1, 8'h03);
      wr(3'h2, 8'h77);
      wr(3'h4, 8'hff);
      wr(3'h0, 8'h40);
      wflag(1'b1, 10);
      wr(3'h0, 8'h80);
      rd(3'h2, 8'h77);
      chk8(nb, 8'h01);
      ack(1'b1);
      // both halves run together, each on its own run bit and flag
      wr(3'h2, 8'hff);
      wr(3'h4, 8'hff);
      wr(3'h0, 8'h50);
      wflag(1'b0, 10);
      wflag(1'b1, 10);
      wr(3'h0, 8'ha0);
      rd(3'h2, 8'h00);
      rd(3'h4, 8'h00);
      ack(1'b0);
      ack(1'b1);
      wr(3'h1, 8'h30);
      wr(3'h3, 8'h05);
      wr(3'h0, 8'h40);
      repeat (20) @(posedge clk);
      rd(3'h3, 8'h05);
      wr(3'h0, 8'h00);
   endtask
   task test_done;
      if (num_errors == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset;
      t_timer16;
      t_mode13;
      t_reload;
      t_count;
      t_split;
      test_done;
   end
   // watchdog
   initial
   begin
      #400000;
      num_errors++;
      test_done;
   end
endmodule
`default_nettype wire
